// ===== hdl/pcp_pkg.sv
// Package: register map, field layout and types of the PLL clock path block
// Function
// RULE1: Power field 01b holds PLL powered down; 00b runs it normally.
// RULE2: Bypass bit 1 feeds distribution from source, skips VCO divider.
// RULE3: Source bit 0 selects external clock input; 1 selects on-chip VCO.
// RULE4: Polarity bit 0 is positive tuning slope; 1 is negative slope.
// RULE5: Reset: PLL off, divider code 000b, divider used, external source.
// RULE6: VCO divider offers ratios one through six from a three-bit field.
// RULE7: PLL on with external source keeps internal VCO off, feeds prescaler.
// RULE8: Host keeps divider in path when source exceeds channel divider limit.
// RULE9: Host sets power field to normal when PLL drives external VCO.
// RULE10: Two-bit field sets antibacklash pulse width of the detector.
// RULE11: Detector compares reference and feedback dividers, drives pump.
// RULE12: Pump mode field: high impedance, normal, forced up, forced down.
// RULE13: Pump current is selectable in eight steps.
// RULE14: Polarity acts only with external VCO, not with internal VCO.
// RULE15: Host writes update bit so buffered settings become active.
// RULE16: Registers are eight bits; unassigned bits read zero, ignore writes.
package pcp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] A_PLL = 10'h010;
  localparam logic [9:0] A_ABL = 10'h017;
  localparam logic [9:0] A_DIV = 10'h1e0;
  localparam logic [9:0] A_SRC = 10'h1e1;
  localparam logic [9:0] A_UPD = 10'h232;

  localparam logic [7:0] M_PLL = 8'hf3;
  localparam logic [7:0] M_ABL = 8'h1f;
  localparam logic [7:0] M_DIV = 8'h07;
  localparam logic [7:0] M_SRC = 8'h03;

  localparam logic [7:0] R_PLL = 8'h01;
  localparam logic [7:0] R_ABL = 8'h00;
  localparam logic [7:0] R_DIV = 8'h00;
  localparam logic [7:0] R_SRC = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PWR_LSB = 0;
  localparam int PWR_MSB = 1;
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 6;
  localparam int POL_BIT = 7;
  localparam int ABL_LSB = 0;
  localparam int ABL_MSB = 1;
  localparam int CUR_LSB = 2;
  localparam int CUR_MSB = 4;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  localparam int BYP_BIT = 0;
  localparam int SEL_BIT = 1;
  localparam int UPD_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings and types
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;

  typedef enum logic [2:0] {
    PCP_PUMP_HIZ  = 3'b000,
    PCP_PUMP_UP   = 3'b001,
    PCP_PUMP_DOWN = 3'b010,
    PCP_PUMP_NORM = 3'b011
  } pcp_pump_mode_t;

  typedef struct packed {
    logic [7:0] pll;
    logic [7:0] abl;
    logic [7:0] vdiv;
    logic [7:0] src;
  } pcp_regs_t;

  localparam pcp_regs_t REGS_RST = '{R_PLL, R_ABL, R_DIV, R_SRC};

  typedef struct packed {
    logic       pwr_down;
    logic       byp;
    logic       src_vco;
    logic       int_vco_on;
    logic       ext_pre;
    logic [2:0] ratio;
    logic [2:0] cur;
    logic [1:0] abl;
    logic       pol_neg;
    logic [2:0] mode;
  } pcp_out_t;

  // Divider code to ratio: 000b is two, codes past four give one
  function automatic logic [2:0] pcp_ratio(input logic [2:0] code);
    case (code)
      3'h0:    pcp_ratio = 3'h2;
      3'h1:    pcp_ratio = 3'h3;
      3'h2:    pcp_ratio = 3'h4;
      3'h3:    pcp_ratio = 3'h5;
      3'h4:    pcp_ratio = 3'h6;
      default: pcp_ratio = 3'h1;
    endcase
  endfunction

endpackage

// ===== hdl/pcp_pfd.sv
// Module: phase detector and pump driver of the PLL clock path block
`timescale 1ns/1ps
`default_nettype none
module pcp_pfd (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ref_div_i,
  input  wire logic       fb_div_i,
  input  wire logic       pwr_down_i,
  input  wire logic [2:0] mode_i,
  input  wire logic [1:0] abl_i,
  input  wire logic       pol_neg_i,
  output logic            pump_up_o,
  output logic            pump_down_o,
  output logic            pump_oe_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UP   = 2'b01,
    ST_DOWN = 2'b10,
    ST_ABL  = 2'b11
  } pcp_pfd_st_t;

  logic [2:0] ref_s, next_ref_s;
  logic [2:0] fb_s, next_fb_s;
  logic [1:0] cnt, next_cnt;
  logic       up, next_up;
  logic       dn, next_dn;
  logic       oe, next_oe;
  logic       ref_rise;
  logic       fb_rise;
  logic       raw_up;
  logic       raw_dn;
  pcp_pfd_st_t st, next_st;

  assign pump_up_o   = up;
  assign pump_down_o = dn;
  assign pump_oe_o   = oe;
  // Edge detect reads only the second and third stages
  assign ref_rise = ref_s[1] && !ref_s[2];
  assign fb_rise  = fb_s[1] && !fb_s[2];

  always_comb begin
    next_ref_s = {ref_s[1:0], ref_div_i};
    next_fb_s  = {fb_s[1:0], fb_div_i};
    next_st    = st;
    next_cnt   = cnt;
    // RULE11: phase compare
    case (st)
      ST_IDLE: begin
        if (ref_rise && fb_rise) next_st = ST_ABL;
        else if (ref_rise) next_st = ST_UP;
        else if (fb_rise) next_st = ST_DOWN;
      end
      ST_UP: if (fb_rise) next_st = ST_ABL;
      ST_DOWN: if (ref_rise) next_st = ST_ABL;
      // RULE10: antibacklash width
      ST_ABL: begin
        if (cnt == abl_i) begin
          next_st  = ST_IDLE;
          next_cnt = 2'h0;
        end else begin
          next_cnt = cnt + 2'h1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    if (pwr_down_i) begin
      next_st  = ST_IDLE;
      next_cnt = 2'h0;
    end
    raw_up = (next_st == ST_UP) || (next_st == ST_ABL);
    raw_dn = (next_st == ST_DOWN) || (next_st == ST_ABL);
    // RULE12: pump mode
    case (mode_i)
      pcp_pkg::PCP_PUMP_UP: begin
        next_up = 1'b1;
        next_dn = 1'b0;
        next_oe = 1'b1;
      end
      pcp_pkg::PCP_PUMP_DOWN: begin
        next_up = 1'b0;
        next_dn = 1'b1;
        next_oe = 1'b1;
      end
      pcp_pkg::PCP_PUMP_NORM: begin
        // RULE4: negative slope swaps directions
        next_up = pol_neg_i ? raw_dn : raw_up;
        next_dn = pol_neg_i ? raw_up : raw_dn;
        next_oe = !pwr_down_i;
      end
      default: begin
        next_up = 1'b0;
        next_dn = 1'b0;
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ref_s <= 3'h0;
      fb_s  <= 3'h0;
      st    <= ST_IDLE;
      cnt   <= 2'h0;
      up    <= 1'b0;
      dn    <= 1'b0;
      oe    <= 1'b0;
    end else begin
      ref_s <= next_ref_s;
      fb_s  <= next_fb_s;
      st    <= next_st;
      cnt   <= next_cnt;
      up    <= next_up;
      dn    <= next_dn;
      oe    <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pump_hiz_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_i == pcp_pkg::PCP_PUMP_HIZ |=> !pump_oe_o)
    else $error("pump drives in high impedance mode");
  force_up_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_i == pcp_pkg::PCP_PUMP_UP |=> pump_up_o && !pump_down_o)
    else $error("forced pump up not applied");
  force_down_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_i == pcp_pkg::PCP_PUMP_DOWN |=> pump_down_o && !pump_up_o)
    else $error("forced pump down not applied");
  abl_width_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (!reset_n_i)
    (st == ST_ABL && cnt == 2'h0 && !pwr_down_i && $stable(abl_i))
      |-> cnt <= abl_i ##[1:4] st == ST_IDLE)
    else $error("antibacklash pulse too long");
  compare_a: assert property ( // RULE11
    @(posedge clk_i) disable iff (!reset_n_i)
    (st == ST_UP && fb_rise && !pwr_down_i) |=> st == ST_ABL)
    else $error("feedback edge did not end pump up");

endmodule
`default_nettype wire

// ===== hdl/pcp_top.sv
// Module: PLL power, clock source and divider path configuration
`timescale 1ns/1ps
`default_nettype none
module pcp_top (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [9:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic       ref_div_i,
  input  wire logic       fb_div_i,
  output logic            pll_power_down_o,
  output logic            dist_bypass_o,
  output logic            source_vco_o,
  output logic            internal_vco_on_o,
  output logic            ext_to_prescaler_o,
  output logic [2:0]      vco_div_ratio_o,
  output logic [2:0]      pump_current_step_o,
  output logic [1:0]      abl_width_o,
  output logic            charge_pump_output_up_o,
  output logic            charge_pump_output_down_o,
  output logic            charge_pump_output_oe_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pcp_pkg::pcp_regs_t shad, next_shad;
  pcp_pkg::pcp_regs_t act, next_act;
  pcp_pkg::pcp_out_t  cfg, next_cfg;
  logic [7:0]         rdata, next_rdata;
  logic               rvalid, next_rvalid;
  logic               upd;

  // Decode of active settings into path controls
  function automatic pcp_pkg::pcp_out_t decode(
    input pcp_pkg::pcp_regs_t r
  );
    pcp_pkg::pcp_out_t o;
    // RULE1: power state
    o.pwr_down = r.pll[pcp_pkg::PWR_MSB:pcp_pkg::PWR_LSB]
                 != pcp_pkg::PWR_NORMAL;
    // RULE2: divider bypass
    o.byp = r.src[pcp_pkg::BYP_BIT];
    // RULE3: source select
    o.src_vco = r.src[pcp_pkg::SEL_BIT];
    // RULE7: external source keeps VCO off
    o.int_vco_on = o.src_vco;
    o.ext_pre = !o.pwr_down && !o.src_vco;
    // RULE6: divider ratio
    o.ratio = pcp_pkg::pcp_ratio(r.vdiv[pcp_pkg::DIV_MSB:pcp_pkg::DIV_LSB]);
    // RULE13: current step
    o.cur = r.abl[pcp_pkg::CUR_MSB:pcp_pkg::CUR_LSB];
    o.abl = r.abl[pcp_pkg::ABL_MSB:pcp_pkg::ABL_LSB];
    // RULE14: polarity ignored for internal VCO
    o.pol_neg = r.pll[pcp_pkg::POL_BIT] && !o.src_vco;
    o.mode = r.pll[pcp_pkg::MODE_MSB:pcp_pkg::MODE_LSB];
    decode = o;
  endfunction

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign upd = reg_wr_i && (reg_addr_i == pcp_pkg::A_UPD)
               && reg_wdata_i[pcp_pkg::UPD_BIT];

  always_comb begin
    next_shad = shad;
    // RULE16: unassigned bits dropped on write
    if (reg_wr_i) begin
      case (reg_addr_i)
        pcp_pkg::A_PLL: next_shad.pll  = reg_wdata_i & pcp_pkg::M_PLL;
        pcp_pkg::A_ABL: next_shad.abl  = reg_wdata_i & pcp_pkg::M_ABL;
        pcp_pkg::A_DIV: next_shad.vdiv = reg_wdata_i & pcp_pkg::M_DIV;
        pcp_pkg::A_SRC: next_shad.src  = reg_wdata_i & pcp_pkg::M_SRC;
        default: ;
      endcase
    end
    // RULE15: update moves buffered settings to active
    next_act = upd ? shad : act;
    next_rvalid = reg_rd_i;
    next_rdata = rdata;
    if (reg_rd_i) begin
      case (reg_addr_i)
        pcp_pkg::A_PLL: next_rdata = shad.pll;
        pcp_pkg::A_ABL: next_rdata = shad.abl;
        pcp_pkg::A_DIV: next_rdata = shad.vdiv;
        pcp_pkg::A_SRC: next_rdata = shad.src;
        default:        next_rdata = 8'h00;
      endcase
    end
    next_cfg = decode(next_act);
  end

  // RULE5: power-up defaults
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shad   <= pcp_pkg::REGS_RST;
      act    <= pcp_pkg::REGS_RST;
      cfg    <= decode(pcp_pkg::REGS_RST);
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      shad   <= next_shad;
      act    <= next_act;
      cfg    <= next_cfg;
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o         = rdata;
  assign reg_rvalid_o        = rvalid;
  assign pll_power_down_o    = cfg.pwr_down;
  assign dist_bypass_o       = cfg.byp;
  assign source_vco_o        = cfg.src_vco;
  assign internal_vco_on_o   = cfg.int_vco_on;
  assign ext_to_prescaler_o  = cfg.ext_pre;
  assign vco_div_ratio_o     = cfg.ratio;
  assign pump_current_step_o = cfg.cur;
  assign abl_width_o         = cfg.abl;

  // ----------------------------------------------------------------
  // Detector and pump
  // ----------------------------------------------------------------
  pcp_pfd u_pfd (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .ref_div_i   (ref_div_i),
    .fb_div_i    (fb_div_i),
    .pwr_down_i  (cfg.pwr_down),
    .mode_i      (cfg.mode),
    .abl_i       (cfg.abl),
    .pol_neg_i   (cfg.pol_neg),
    .pump_up_o   (charge_pump_output_up_o),
    .pump_down_o (charge_pump_output_down_o),
    .pump_oe_o   (charge_pump_output_oe_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  update_copy_a: assert property ( // RULE15
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> act == $past(shad))
    else $error("update did not load active settings");
  hold_active_a: assert property ( // RULE15
    @(posedge clk_i) disable iff (!reset_n_i)
    (reg_wr_i && !upd) |=> $stable(act))
    else $error("active settings moved without update");
  power_state_a: assert property ( // RULE1
    @(posedge clk_i) disable iff (!reset_n_i)
    upd && shad.pll[pcp_pkg::PWR_MSB:pcp_pkg::PWR_LSB] == pcp_pkg::PWR_DOWN
      |=> pll_power_down_o)
    else $error("power-down code did not stop the PLL");
  power_normal_a: assert property ( // RULE1
    @(posedge clk_i) disable iff (!reset_n_i)
    upd && shad.pll[pcp_pkg::PWR_MSB:pcp_pkg::PWR_LSB] == pcp_pkg::PWR_NORMAL
      |=> !pll_power_down_o)
    else $error("normal code left the PLL off");
  bypass_path_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> dist_bypass_o == $past(shad.src[pcp_pkg::BYP_BIT]))
    else $error("bypass does not follow setting");
  source_sel_a: assert property ( // RULE3
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> source_vco_o == $past(shad.src[pcp_pkg::SEL_BIT]))
    else $error("source does not follow setting");
  vco_src_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> internal_vco_on_o == $past(shad.src[pcp_pkg::SEL_BIT]))
    else $error("internal VCO power does not follow source");
  reset_dflt_a: assert property ( // RULE5
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> pll_power_down_o && vco_div_ratio_o == 3'h2
      && !dist_bypass_o && !source_vco_o)
    else $error("reset defaults wrong");
  div_range_a: assert property ( // RULE6
    @(posedge clk_i) disable iff (!reset_n_i)
    vco_div_ratio_o >= 3'h1 && vco_div_ratio_o <= 3'h6)
    else $error("divider ratio out of range");
  div_two_a: assert property ( // RULE6
    @(posedge clk_i) disable iff (!reset_n_i)
    upd && shad.vdiv[pcp_pkg::DIV_MSB:pcp_pkg::DIV_LSB] == 3'h0
      |=> vco_div_ratio_o == 3'h2)
    else $error("divider code zero is not divide by two");
  vco_off_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (!reset_n_i)
    (!pll_power_down_o && !source_vco_o)
      |-> !internal_vco_on_o && ext_to_prescaler_o)
    else $error("internal VCO on with external source");
  pol_gate_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (!reset_n_i)
    source_vco_o |-> !cfg.pol_neg)
    else $error("polarity applied to internal VCO");
  abl_follow_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> abl_width_o == $past(shad.abl[pcp_pkg::ABL_MSB:pcp_pkg::ABL_LSB]))
    else $error("antibacklash width does not follow setting");
  step_sel_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (!reset_n_i)
    upd |=> pump_current_step_o
      == $past(shad.abl[pcp_pkg::CUR_MSB:pcp_pkg::CUR_LSB]))
    else $error("current step does not follow setting");
  zero_bits_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == pcp_pkg::A_DIV) |=> reg_rdata_o[7:3] == 5'h00)
    else $error("unassigned bits read nonzero");
  zero_pll_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == pcp_pkg::A_PLL)
      |=> (reg_rdata_o & ~pcp_pkg::M_PLL) == 8'h00)
    else $error("unassigned power register bits read nonzero");
  zero_src_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == pcp_pkg::A_SRC)
      |=> (reg_rdata_o & ~pcp_pkg::M_SRC) == 8'h00)
    else $error("unassigned source register bits read nonzero");
  unmapped_rd_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == pcp_pkg::A_UPD) |=> reg_rdata_o == 8'h00)
    else $error("unmapped address read nonzero");

endmodule
`default_nettype wire

// ===== tb/pll_clock_path_config_tb_top.sv
// Testbench: self-checking bench of the PLL clock path configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  err_count++; \
  $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp); end end
module pll_clock_path_config_tb_top;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       ref_div_i = 1'b0;
  logic       fb_div_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       reg_rvalid_o;
  logic       pd_o, byp_o, sv_o, ivco_o, pre_o, up_o, dn_o, oe_o;
  logic [2:0] ratio_o, cur_o;
  logic [1:0] abl_o;
  int         err_count = 0;
  int         n_compared = 0;
  logic [31:0] lfsr = 32'h6dbe9475;
  logic [9:0] addrs [4];
  logic [7:0] msk [4];
  logic [7:0] sh [4];
  logic [7:0] act [4];

  pcp_top u_dut (
    .clk_i                     (clk_i),
    .reset_n_i                 (reset_n_i),
    .reg_addr_i                (reg_addr_i),
    .reg_wdata_i               (reg_wdata_i),
    .reg_wr_i                  (reg_wr_i),
    .reg_rd_i                  (reg_rd_i),
    .reg_rdata_o               (reg_rdata_o),
    .reg_rvalid_o              (reg_rvalid_o),
    .ref_div_i                 (ref_div_i),
    .fb_div_i                  (fb_div_i),
    .pll_power_down_o          (pd_o),
    .dist_bypass_o             (byp_o),
    .source_vco_o              (sv_o),
    .internal_vco_on_o         (ivco_o),
    .ext_to_prescaler_o        (pre_o),
    .vco_div_ratio_o           (ratio_o),
    .pump_current_step_o       (cur_o),
    .abl_width_o               (abl_o),
    .charge_pump_output_up_o   (up_o),
    .charge_pump_output_down_o (dn_o),
    .charge_pump_output_oe_o   (oe_o)
  );

  always #12.5 clk_i = ~clk_i;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  function automatic logic [12:0] exp_out();
    logic       pd;
    logic [2:0] code;
    pd = act[0][1:0] != 2'h0;
    code = act[2][2:0];
    return {pd, act[3][0], act[3][1], act[3][1], !pd && !act[3][1],
            (code <= 3'h4) ? code + 3'h2 : 3'h1, act[1][4:2], act[1][1:0]};
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    #2;
    reset_n_i = 1'b0;
    repeat (12) @(posedge clk_i);
    #2;
    reset_n_i = 1'b1;
    sh = '{pcp_pkg::R_PLL, pcp_pkg::R_ABL, pcp_pkg::R_DIV, pcp_pkg::R_SRC};
    act = sh;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #2;
    reg_wr_i = 1'b0;
  endtask

  task automatic set(input int i, input logic [7:0] d);
    wr(addrs[i], d);
    sh[i] = d & msk[i];
  endtask

  task automatic upd();
    wr(pcp_pkg::A_UPD, 8'h01);
    act = sh;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    int n;
    @(posedge clk_i);
    #2;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i);
    #2;
    reg_rd_i = 1'b0;
    n = 0;
    while (reg_rvalid_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    if (n == 4) begin
      err_count++;
      $display("[FAIL] %0t ns: read answer missing", $time);
      end_of_test();
    end else begin
      `CHK(reg_rdata_o, e)
    end
  endtask

  task automatic chk_out();
    `CHK({pd_o, byp_o, sv_o, ivco_o, pre_o, ratio_o, cur_o, abl_o}, exp_out())
  endtask

  task automatic pfd(input logic neg, input logic [7:0] srcv);
    int cnt;
    logic swap;
    set(0, {neg, 7'h30});
    set(3, srcv);
    set(1, 8'h02);
    upd();
    swap = neg && !srcv[1];
    ref_div_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #2;
    `CHK({up_o, dn_o, oe_o}, {!swap, swap, 1'b1})
    fb_div_i = 1'b1;
    cnt = 0;
    repeat (12) begin
      @(posedge clk_i);
      #2;
      if (up_o === 1'b1 && dn_o === 1'b1) cnt++;
    end
    `CHK(cnt, 3)
    `CHK({up_o, dn_o, oe_o}, 3'b001)
    ref_div_i = 1'b0;
    fb_div_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #2;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [2:0] modes [4];
    logic [2:0] pexp [4];
    addrs = '{pcp_pkg::A_PLL, pcp_pkg::A_ABL, pcp_pkg::A_DIV, pcp_pkg::A_SRC};
    msk = '{pcp_pkg::M_PLL, pcp_pkg::M_ABL, pcp_pkg::M_DIV, pcp_pkg::M_SRC};
    modes = '{3'b001, 3'b010, 3'b000, 3'b011};
    pexp = '{3'b101, 3'b011, 3'b000, 3'b000};
    do_reset();
    chk_out();
    for (int i = 0; i < 4; i++) rd(addrs[i], sh[i]);
    `CHK({up_o, dn_o, oe_o}, 3'b000)
    $display("test reset defaults done");
    for (int i = 0; i < 4; i++) begin
      set(i, 8'hff);
      rd(addrs[i], msk[i]);
    end
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    rd(pcp_pkg::A_UPD, 8'h00);
    chk_out();
    upd();
    chk_out();
    $display("test register masks done");
    for (int i = 0; i < 8; i++) begin
      set(2, 8'(i));
      set(3, 8'h01);
      upd();
      chk_out();
    end
    $display("test divider codes done");
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 4; i++) set(i, rnd());
      chk_out();
      upd();
      chk_out();
      rd(addrs[k % 4], sh[k % 4]);
    end
    $display("test random settings done");
    for (int m = 0; m < 4; m++) begin
      set(0, {1'b0, modes[m], 4'h1});
      upd();
      @(posedge clk_i);
      #2;
      `CHK({up_o, dn_o, oe_o}, pexp[m])
    end
    $display("test pump modes done");
    pfd(1'b0, 8'h00);
    pfd(1'b1, 8'h00);
    pfd(1'b1, 8'h02);
    chk_out();
    $display("test detector done");
    do_reset();
    chk_out();
    rd(pcp_pkg::A_PLL, pcp_pkg::R_PLL);
    $display("test second reset done");
    end_of_test();
  end

  initial begin
    #(25.0 * 100000);
    err_count++;
    $display("[FAIL] %0t ns: run limit reached", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
